/* File: design/bfu_pkg.sv */
package bfu_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Command framing
  localparam logic [7:0] CLA_STD       = 8'h00;
  localparam logic [7:0] INS_UPDATE    = 8'hD6;
  localparam logic [8:0] HDR_LC_IDX    = 9'h004;
  localparam logic [4:0] SFI_SELECTED  = 5'h00;
  localparam logic [4:0] SFI_RESERVED  = 5'h1F;
  localparam logic [3:0] ACCESS_FREE   = 4'hE;
  localparam int         MAX_DATA      = 255;
  localparam int         NUM_FILES     = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Status words
  localparam logic [15:0] SW_OK        = 16'h9000;
  localparam logic [15:0] SW_MEM_FAIL  = 16'h6581;
  localparam logic [15:0] SW_LEN       = 16'h6700;
  localparam logic [15:0] SW_SECURITY  = 16'h6982;
  localparam logic [15:0] SW_COND      = 16'h6985;
  localparam logic [15:0] SW_NOT_FOUND = 16'h6A82;
  localparam logic [15:0] SW_P1P2      = 16'h6A86;
  localparam logic [15:0] SW_INS       = 16'h6D00;
  localparam logic [15:0] SW_CLA       = 16'h6E00;

  ////////////////////////////////////////////////////////////////////////////
  // Register map and fields
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS   = 8'h04;
  localparam logic [7:0]  ADDR_SELECT   = 8'h08;
  localparam logic [7:0]  ADDR_FILE0    = 8'h10;
  localparam int          CTRL_AES_BIT  = 0;
  localparam int          CTRL_LRP_BIT  = 1;
  localparam int          CTRL_CHAIN_BIT = 2;
  localparam int          SEL_VALID_BIT = 8;
  localparam int          STAT_BUSY_BIT = 3;
  localparam int          STAT_SW_LSB   = 16;
  localparam logic [31:0] REG_RST       = 32'h0000_0000;
  localparam logic [1:0]  AXI_OKAY      = 2'b00;
  localparam logic [1:0]  AXI_SLVERR    = 2'b10;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [7:0] {
    ST_HDR    = 8'h01,
    ST_DATA   = 8'h02,
    ST_DRAIN  = 8'h04,
    ST_CHECK  = 8'h08,
    ST_WRITE  = 8'h10,
    ST_COMMIT = 8'h20,
    ST_RESP1  = 8'h40,
    ST_RESP2  = 8'h80
  } bfu_state_type;

  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } bfu_byte_type;

  typedef struct packed {
    logic [1:0]  file;
    logic [14:0] addr;
    logic [7:0]  data;
    logic        last;
  } bfu_nvm_type;

  typedef struct packed {
    logic        pad;
    logic [14:0] size;
    logic [3:0]  rw_right;
    logic [3:0]  wr_right;
    logic        plain_comm_setting;
    logic        std_data;
    logic        exist;
    logic [4:0]  sfi;
  } bfu_file_type;

endpackage : bfu_pkg

/* File: design/bfu_rsp_buf.sv */
module bfu_rsp_buf #(
  parameter int W     = 9,
  parameter int DEPTH = 2
) (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  import bfu_pkg::*;

  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [PW:0]             cnt;
  } bfu_buf_type;

  bfu_buf_type buf_r;
  bfu_buf_type buf_nxt;
  logic        push;
  logic        pop;

  assign in_ready  = (buf_r.cnt != (PW+1)'(DEPTH));
  assign out_valid = (buf_r.cnt != '0);
  assign out_data  = buf_r.mem[buf_r.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    buf_nxt = buf_r;
    if (push) begin
      buf_nxt.mem[buf_r.wp] = in_data;
      buf_nxt.wp            = (buf_r.wp == PW'(DEPTH - 1)) ? '0 : buf_r.wp + PW'(1);
    end
    if (pop) begin
      buf_nxt.rp = (buf_r.rp == PW'(DEPTH - 1)) ? '0 : buf_r.rp + PW'(1);
    end
    buf_nxt.cnt = buf_r.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      buf_r <= '0;
    end else begin
      buf_r <= buf_nxt;
    end
  end

endmodule : bfu_rsp_buf

/* File: design/bfu_update.sv */
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// - Only plain standard data files accept updates
// - Whole frame is committed or nothing
// - P1 bit7 set: short id, offset 0-255
// - P1 bit7 clear: 15-bit offset from P1,P2
// - Id 0 current, 1-1E select, 1F reserved
// - Write needs free write or read-write access right
// - Active secure session rejects with 6982h
// - Chain ongoing or no file selected gives 6985h
// - Writes past file end give 6985h
// - Bad frame length gives 6700h
// - Bad P1 or P2 gives 6A86h
// - Success returns 9000h only
module bfu_update (
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire bfu_pkg::bfu_byte_type cmd_in,
  input  wire logic                 cmd_valid,
  output logic                      cmd_ready,
  output bfu_pkg::bfu_byte_type     rsp_out,
  output logic                      rsp_valid,
  input  wire logic                 rsp_ready,
  output bfu_pkg::bfu_nvm_type      nvm_req,
  output logic                      nvm_valid,
  input  wire logic                 nvm_ready,
  input  wire logic                 nvm_ack,
  input  wire logic                 nvm_fail
);
  import bfu_pkg::*;

  typedef struct packed {
    bfu_state_type                  st;
    logic [8:0]                     cnt;
    logic [7:0]                     cla;
    logic [7:0]                     ins;
    logic [7:0]                     p1;
    logic [7:0]                     p2;
    logic [7:0]                     lc;
    logic                           len_err;
    logic [15:0]                    sw;
    logic [14:0]                    off;
    logic [1:0]                     file;
    logic [7:0]                     ptr;
    bfu_nvm_type                    nvm;
    logic                           nvm_valid;
    logic [31:0]                    ctrl;
    logic                           sel_valid;
    logic [1:0]                     sel;
    bfu_file_type [NUM_FILES-1:0]   files;
    logic                           aw_got;
    logic [7:0]                     awaddr;
    logic                           w_got;
    logic [31:0]                    wdata;
    logic [3:0]                     wstrb;
    logic                           bvalid;
    logic [1:0]                     bresp;
    logic                           rvalid;
    logic [31:0]                    rdata;
    logic [1:0]                     rresp;
  } bfu_core_type;

  bfu_core_type r;
  bfu_core_type r_nxt;
  logic [7:0]   data_buf [MAX_DATA];
  bfu_byte_type rsp_in;
  logic         rsp_in_valid;
  logic         rsp_in_ready;
  logic         cmd_take;

  function automatic logic free_access(input bfu_file_type f);
    return (f.wr_right == ACCESS_FREE) || (f.rw_right == ACCESS_FREE);
  endfunction : free_access

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  assign cmd_ready     = (r.st == ST_HDR) || (r.st == ST_DATA) || (r.st == ST_DRAIN);
  assign cmd_take      = cmd_valid && cmd_ready;
  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready  = !r.w_got && !r.bvalid;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign nvm_req       = r.nvm;
  assign nvm_valid     = r.nvm_valid;
  assign rsp_in_valid  = (r.st == ST_RESP1) || (r.st == ST_RESP2);
  assign rsp_in.data   = (r.st == ST_RESP1) ? r.sw[15:8] : r.sw[7:0];
  assign rsp_in.last   = (r.st == ST_RESP2);

  ////////////////////////////////////////////////////////////////////////////
  // Frame staging: data is held here until the whole frame is checked
  always_ff @(posedge sys_clk) begin
    if (r.st == ST_DATA && cmd_take && r.cnt < 9'(MAX_DATA)) begin
      data_buf[r.cnt[7:0]] <= cmd_in.data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command engine and register slave
  always_comb begin
    logic [14:0]  off_c;
    logic [4:0]   sfi;
    logic         found;
    logic [1:0]   hit;
    logic [1:0]   tgt;
    logic [15:0]  end_c;
    logic [7:0]   nidx;
    bfu_file_type f;
    off_c = '0;
    sfi   = '0;
    found = 1'b0;
    hit   = '0;
    tgt   = '0;
    end_c = '0;
    nidx  = '0;
    f     = '0;
    r_nxt = r;

    case (r.st)
      ST_HDR: begin
        if (cmd_take) begin
          r_nxt.cnt = r.cnt + 9'h001;
          case (r.cnt[2:0])
            3'h0: r_nxt.cla = cmd_in.data;
            3'h1: r_nxt.ins = cmd_in.data;
            3'h2: r_nxt.p1 = cmd_in.data;
            3'h3: r_nxt.p2 = cmd_in.data;
            default: r_nxt.lc = cmd_in.data;
          endcase
          if (r.cnt == HDR_LC_IDX) begin
            r_nxt.cnt = '0;
            if (cmd_in.last || cmd_in.data == 8'h00) begin
              r_nxt.len_err = 1'b1;
              r_nxt.st      = cmd_in.last ? ST_CHECK : ST_DRAIN;
            end else begin
              r_nxt.st = ST_DATA;
            end
          end else if (cmd_in.last) begin
            r_nxt.len_err = 1'b1;
            r_nxt.st      = ST_CHECK;
          end
        end
      end
      ST_DATA: begin
        if (cmd_take) begin
          r_nxt.cnt = r.cnt + 9'h001;
          if (cmd_in.last) begin
            r_nxt.len_err = (r.cnt + 9'h001 != {1'b0, r.lc});
            r_nxt.st      = ST_CHECK;
          end else if (r.cnt + 9'h001 == {1'b0, r.lc}) begin
            r_nxt.len_err = 1'b1;
            r_nxt.st      = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        if (cmd_take && cmd_in.last) begin
          r_nxt.st = ST_CHECK;
        end
      end
      ST_CHECK: begin
        off_c = r.p1[7] ? {7'h00, r.p2} : {r.p1[6:0], r.p2};
        sfi   = r.p1[4:0];
        for (int i = 0; i < NUM_FILES; i++) begin
          if (r.files[i].exist && r.files[i].sfi == sfi) begin
            found = 1'b1;
            hit   = 2'(i);
          end
        end
        tgt   = (r.p1[7] && sfi != SFI_SELECTED) ? hit : r.sel;
        f     = r.files[tgt];
        end_c = {1'b0, off_c} + {8'h00, r.lc};
        r_nxt.off  = off_c;
        r_nxt.file = tgt;
        r_nxt.st   = ST_RESP1;
        if (r.cla != CLA_STD) begin
          r_nxt.sw = SW_CLA;
        end else if (r.ins != INS_UPDATE) begin
          r_nxt.sw = SW_INS;
        end else if (r.len_err) begin
          r_nxt.sw = SW_LEN;
        end else if (r.ctrl[CTRL_CHAIN_BIT]) begin
          r_nxt.sw = SW_COND;
        end else if (r.ctrl[CTRL_AES_BIT] || r.ctrl[CTRL_LRP_BIT]) begin
          r_nxt.sw = SW_SECURITY;
        end else if (r.p1[7] && (r.p1[6:5] != 2'b00 || sfi == SFI_RESERVED)) begin
          r_nxt.sw = SW_P1P2;
        end else if (r.p1[7] && sfi != SFI_SELECTED && !found) begin
          r_nxt.sw = SW_NOT_FOUND;
        end else if ((!r.p1[7] || sfi == SFI_SELECTED) && !r.sel_valid) begin
          r_nxt.sw = SW_COND;
        end else if (!f.exist) begin
          r_nxt.sw = SW_NOT_FOUND;
        end else if (!f.std_data || !f.plain_comm_setting) begin
          r_nxt.sw = SW_COND;
        end else if (!free_access(f)) begin
          r_nxt.sw = SW_SECURITY;
        end else if (end_c > {1'b0, f.size}) begin
          r_nxt.sw = SW_COND;
        end else begin
          r_nxt.sw        = SW_OK;
          r_nxt.st        = ST_WRITE;
          r_nxt.nvm       = '{file: tgt, addr: off_c, data: data_buf[0], last: (r.lc == 8'h01)};
          r_nxt.nvm_valid = 1'b1;
          r_nxt.ptr       = 8'h01;
        end
        // A found short id stays selected even if a later check refuses the write
        if (r.cla == CLA_STD && r.ins == INS_UPDATE && !r.len_err && !r.ctrl[CTRL_CHAIN_BIT] &&
            !r.ctrl[CTRL_AES_BIT] && !r.ctrl[CTRL_LRP_BIT] && r.p1[7] && r.p1[6:5] == 2'b00 &&
            sfi != SFI_SELECTED && sfi != SFI_RESERVED && found) begin
          r_nxt.sel       = hit;
          r_nxt.sel_valid = 1'b1;
        end
      end
      ST_WRITE: begin
        if (r.nvm_valid && nvm_ready) begin
          if (r.nvm.last) begin
            r_nxt.nvm_valid = 1'b0;
            r_nxt.st        = ST_COMMIT;
          end else begin
            nidx      = r.ptr;
            r_nxt.nvm = '{file: r.file, addr: r.off + {7'h00, nidx}, data: data_buf[nidx],
                          last: (r.ptr + 8'h01 == r.lc)};
            r_nxt.ptr = r.ptr + 8'h01;
          end
        end
      end
      ST_COMMIT: begin
        if (nvm_ack) begin
          r_nxt.sw = nvm_fail ? SW_MEM_FAIL : SW_OK;
          r_nxt.st = ST_RESP1;
        end
      end
      ST_RESP1: begin
        if (rsp_in_ready) begin
          r_nxt.st = ST_RESP2;
        end
      end
      ST_RESP2: begin
        if (rsp_in_ready) begin
          r_nxt.st      = ST_HDR;
          r_nxt.cnt     = '0;
          r_nxt.len_err = 1'b0;
        end
      end
      default: begin
        r_nxt.st = ST_HDR;
      end
    endcase

    // Register slave; a select write is dropped while the next state is ST_RESP1, so hardware selection wins only on a refused check
    if (s_axi_awvalid && s_axi_awready) begin
      r_nxt.aw_got = 1'b1;
      r_nxt.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      r_nxt.w_got = 1'b1;
      r_nxt.wdata = s_axi_wdata;
      r_nxt.wstrb = s_axi_wstrb;
    end
    if (r.aw_got && r.w_got) begin
      r_nxt.aw_got = 1'b0;
      r_nxt.w_got  = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp  = AXI_OKAY;
      if (r.awaddr == ADDR_CTRL) begin
        r_nxt.ctrl = merge(r.ctrl, r.wdata, r.wstrb) & 32'h0000_0007;
      end else if (r.awaddr == ADDR_SELECT && r_nxt.st != ST_RESP1) begin
        r_nxt.sel       = 2'(merge({23'h00_0000, r.sel_valid, 6'h00, r.sel}, r.wdata, r.wstrb));
        r_nxt.sel_valid = r.wdata[SEL_VALID_BIT] && r.wstrb[1];
      end else if (r.awaddr >= ADDR_FILE0 && r.awaddr < ADDR_FILE0 + 8'(4 * NUM_FILES) &&
                   r.awaddr[1:0] == 2'b00) begin
        r_nxt.files[r.awaddr[3:2]] = merge(r.files[r.awaddr[3:2]], r.wdata, r.wstrb);
      end else if (r.awaddr != ADDR_SELECT) begin
        r_nxt.bresp = AXI_SLVERR;
      end
    end else if (r.bvalid && s_axi_bready) begin
      r_nxt.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      r_nxt.rvalid = 1'b1;
      r_nxt.rresp  = AXI_OKAY;
      r_nxt.rdata  = REG_RST;
      if (s_axi_araddr == ADDR_CTRL) begin
        r_nxt.rdata = r.ctrl;
      end else if (s_axi_araddr == ADDR_STATUS) begin
        r_nxt.rdata[STAT_SW_LSB +: 16] = r.sw;
        r_nxt.rdata[STAT_BUSY_BIT]     = !(r.st == ST_HDR && r.cnt == '0);
        r_nxt.rdata[2:0]               = {r.sel_valid, r.sel};
      end else if (s_axi_araddr == ADDR_SELECT) begin
        r_nxt.rdata[SEL_VALID_BIT] = r.sel_valid;
        r_nxt.rdata[1:0]           = r.sel;
      end else if (s_axi_araddr >= ADDR_FILE0 && s_axi_araddr < ADDR_FILE0 + 8'(4 * NUM_FILES) &&
                   s_axi_araddr[1:0] == 2'b00) begin
        r_nxt.rdata = r.files[s_axi_araddr[3:2]];
      end else begin
        r_nxt.rresp = AXI_SLVERR;
      end
    end else if (r.rvalid && s_axi_rready) begin
      r_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      r    <= '0;
      r.st <= ST_HDR;
    end else begin
      r <= r_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word path; the buffer lets the reader stall without losing a byte
  bfu_rsp_buf #(
    .W     (9),
    .DEPTH (2)
  ) u_rsp_buf (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_data   (rsp_in),
    .in_valid  (rsp_in_valid),
    .in_ready  (rsp_in_ready),
    .out_data  (rsp_out),
    .out_valid (rsp_valid),
    .out_ready (rsp_ready)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);

  logic hdr_ok;
  assign hdr_ok = (r.cla == CLA_STD) && (r.ins == INS_UPDATE);

  wrong_class_a: assert property ((r.st == ST_CHECK && r.cla != CLA_STD) |=>
                                  (r.sw == SW_CLA && r.st == ST_RESP1))
    else $error("wrong class not answered with 6E00h");
  bad_length_a: assert property ((r.st == ST_CHECK && hdr_ok && r.len_err) |=> (r.sw == SW_LEN))
    else $error("length error not answered with 6700h");
  chain_busy_a: assert property ((r.st == ST_CHECK && hdr_ok && !r.len_err && r.ctrl[CTRL_CHAIN_BIT]) |=>
                                 r.sw == SW_COND)
    else $error("ongoing chain not answered with 6985h");
  session_block_a: assert property ((r.st == ST_CHECK && hdr_ok && !r.len_err && !r.ctrl[CTRL_CHAIN_BIT] &&
                                     (r.ctrl[CTRL_AES_BIT] || r.ctrl[CTRL_LRP_BIT])) |=> r.sw == SW_SECURITY)
    else $error("active session not answered with 6982h");
  write_gate_a: assert property (r.nvm_valid |-> (free_access(r.files[r.nvm.file]) && r.files[r.nvm.file].std_data &&
                                                  r.files[r.nvm.file].plain_comm_setting))
    else $error("write issued to a file without free plain access");
  file_bound_a: assert property (r.nvm_valid |-> ({1'b0, r.nvm.addr} < {1'b0, r.files[r.nvm.file].size}))
    else $error("write issued beyond file end");
  whole_frame_a: assert property ((r.nvm_valid && r.nvm.last) |-> (r.ptr == r.lc))
    else $error("commit marked before all frame bytes");
  offset_form_a: assert property ((r.st == ST_WRITE) |->
                                  (r.off == (r.p1[7] ? {7'h00, r.p2} : {r.p1[6:0], r.p2})))
    else $error("write offset not formed from P1 and P2");
  mem_fail_a: assert property ((r.st == ST_COMMIT && nvm_ack && nvm_fail) |=>
                               (r.sw == SW_MEM_FAIL && r.st == ST_RESP1))
    else $error("memory failure not answered with 6581h");
  success_a: assert property ((r.st == ST_COMMIT && nvm_ack && !nvm_fail) |=>
                              (r.sw == SW_OK) ##1 (r.st != ST_WRITE))
    else $error("success not answered with 9000h");

  write_done_c: cover property (r.st == ST_COMMIT && nvm_ack && !nvm_fail);
  write_fail_c: cover property (r.st == ST_COMMIT && nvm_ack && nvm_fail);
  reject_c: cover property (r.st == ST_CHECK ##1 r.st == ST_RESP1 && r.sw == SW_COND);
  rsp_stall_c: cover property (rsp_in_valid && !rsp_in_ready);

endmodule : bfu_update

/* File: tb/bfu_nvm_model.sv */
module bfu_nvm_model (
  input  wire logic                 sys_clk,
  input  wire logic                 reset,
  input  wire bfu_pkg::bfu_nvm_type nvm_req,
  input  wire logic                 nvm_valid,
  output logic                      nvm_ready,
  output logic                      nvm_ack,
  output logic                      nvm_fail,
  input  wire logic                 slow,
  input  wire logic                 fail_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  import bfu_pkg::*;
  int   commits;
  int   jrnl;
  logic pend;
  ////////////////////////////////////////////////////////////////////////////
  // Bytes stay in the journal until the frame's ack, so a torn frame shows none
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nvm_ready <= 1'b0;
      nvm_ack   <= 1'b0;
      nvm_fail  <= 1'b0;
      pend      <= 1'b0;
      jrnl      <= 0;
      commits   <= 0;
    end else begin
      nvm_ready <= slow ? !nvm_ready : 1'b1;
      nvm_ack   <= pend;
      nvm_fail  <= pend && fail_mode;
      pend      <= nvm_valid && nvm_ready && nvm_req.last;
      if (nvm_valid && nvm_ready) begin
        jrnl <= jrnl + 1;
      end
      if (pend) begin
        jrnl <= 0;
        if (!fail_mode) begin
          commits <= commits + jrnl;
        end
      end
    end
  end
endmodule : bfu_nvm_model

/* File: tb/testbench.sv */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import bfu_pkg::*;
  logic         sys_clk, reset, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic         s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, cmd_valid;
  logic         cmd_ready, rsp_valid, rsp_ready, nvm_valid, nvm_ready, nvm_ack, nvm_fail, slow, fail;
  logic [7:0]   s_axi_awaddr, s_axi_araddr;
  logic [31:0]  s_axi_wdata, s_axi_rdata;
  logic [3:0]   s_axi_wstrb;
  logic [1:0]   s_axi_bresp, s_axi_rresp;
  bfu_byte_type cmd_in, rsp_out;
  bfu_nvm_type  nvm_req;
  int           error_cnt, cmp_count;

  bfu_update u_bfu_update (.*);
  bfu_nvm_model u_bfu_nvm_model (.sys_clk, .reset, .nvm_req, .nvm_valid, .nvm_ready, .nvm_ack,
                                 .nvm_fail, .slow, .fail_mode(fail));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Compares %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  task automatic tmo();
    error_cnt++;
    give_verdict();
  endtask : tmo

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Ready is sampled at the falling edge so the release lands right after the taking edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ka, kw, kb;
    logic [1:0] rs;
    n = 0;
    kb = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!kb) begin
      @(negedge sys_clk);
      ka = s_axi_awready === 1'b1;
      kw = s_axi_wready === 1'b1;
      kb = s_axi_bvalid === 1'b1;
      rs = s_axi_bresp;
      @(posedge sys_clk);
      if (ka) s_axi_awvalid <= 1'b0;
      if (kw) s_axi_wvalid <= 1'b0;
      if (++n > 50) tmo();
    end
    chk("bresp", {30'h0, er}, {30'h0, rs});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    logic ka, kr;
    logic [31:0] d;
    logic [1:0] rs;
    n = 0;
    kr = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!kr) begin
      @(negedge sys_clk);
      ka = s_axi_arready === 1'b1;
      kr = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge sys_clk);
      if (ka) s_axi_arvalid <= 1'b0;
      if (++n > 50) tmo();
    end
    chk("rdata", e, d);
    chk("rresp", {30'h0, er}, {30'h0, rs});
  endtask : rd

  // One whole command per call, never a transport chain
  task automatic ap(input logic [7:0] cla, p1, p2, lc, input int nd, input logic [15:0] e, input int st);
    logic [7:0] q[$];
    bfu_byte_type b[2];
    int n, k;
    n = 0;
    q = '{cla, INS_UPDATE, p1, p2, lc};
    for (int i = 0; i < nd; i++) q.push_back(8'ha0 + 8'(i));
    foreach (q[i]) begin
      cmd_in <= '{q[i], i == q.size() - 1};
      cmd_valid <= 1'b1;
      k = 0;
      while (k == 0) begin
        @(negedge sys_clk);
        k = int'(cmd_ready === 1'b1);
        @(posedge sys_clk);
        if (++n > 500) tmo();
      end
    end
    cmd_valid <= 1'b0;
    if (st > 0) begin
      repeat (st) @(negedge sys_clk);
      chk("rsp_held", 32'h0000_0001, {31'h0, rsp_valid});
      @(posedge sys_clk);
      rsp_ready <= 1'b1;
    end
    k = 0;
    while (k < 2) begin
      @(negedge sys_clk);
      if (rsp_valid === 1'b1) begin
        b[k] = rsp_out;
        k++;
      end
      @(posedge sys_clk);
      if (++n > 500) tmo();
    end
    chk("status_word", {14'h0, e[15:8], 1'b0, e[7:0], 1'b1}, {14'h0, b[0], b[1]});
  endtask : ap
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, cmd_valid, slow, fail} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, cmd_in} = '0;
    {s_axi_bready, s_axi_rready, rsp_ready, reset} = '1;
    s_axi_wstrb = 4'hf;
    repeat (6) @(posedge sys_clk);
    reset <= 1'b0;
    rd(ADDR_STATUS, REG_RST, AXI_OKAY);
    wr(ADDR_FILE0, 32'h0010_0ee1, AXI_OKAY);
    wr(ADDR_FILE0 + 8'h04, 32'h0010_00e2, AXI_OKAY);
    wr(ADDR_FILE0 + 8'h08, 32'h0010_e0e3, AXI_OKAY);
    ap(8'h01, 8'h00, 8'h00, 8'h01, 1, 16'h6e00, 0);
    ap(8'h00, 8'h00, 8'h00, 8'h01, 1, 16'h6985, 0);
    ap(8'h00, 8'h9f, 8'h00, 8'h01, 1, 16'h6a86, 0);
    ap(8'h00, 8'ha1, 8'h00, 8'h01, 1, 16'h6a86, 0);
    ap(8'h00, 8'h84, 8'h00, 8'h01, 1, 16'h6a82, 0);
    ap(8'h00, 8'h82, 8'h00, 8'h01, 1, 16'h6982, 0);
    ap(8'h00, 8'h83, 8'h00, 8'h01, 1, 16'h9000, 0);
    slow <= 1'b1;
    ap(8'h00, 8'h81, 8'h0d, 8'h03, 3, 16'h9000, 0);
    slow <= 1'b0;
    chk("commits", 32'h0000_0004, u_bfu_nvm_model.commits);
    ap(8'h00, 8'h00, 8'h0e, 8'h03, 3, 16'h6985, 0);
    ap(8'h00, 8'h00, 8'h0d, 8'h03, 3, 16'h9000, 0);
    ap(8'h00, 8'h00, 8'h00, 8'h02, 1, 16'h6700, 0);
    ap(8'h00, 8'h00, 8'h00, 8'h00, 0, 16'h6700, 0);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_CTRL, 32'h0000_0001 << i, AXI_OKAY);
      ap(8'h00, 8'h81, 8'h00, 8'h01, 1, i == 2 ? 16'h6985 : 16'h6982, 0);
    end
    wr(ADDR_CTRL, REG_RST, AXI_OKAY);
    wr(ADDR_FILE0, 32'h0010_0e61, AXI_OKAY);
    ap(8'h00, 8'h81, 8'h00, 8'h01, 1, 16'h6985, 0);
    wr(ADDR_FILE0, 32'h0010_0ee1, AXI_OKAY);
    fail <= 1'b1;
    ap(8'h00, 8'h81, 8'h00, 8'h01, 1, 16'h6581, 0);
    fail <= 1'b0;
    chk("commits", 32'h0000_0007, u_bfu_nvm_model.commits);
    rsp_ready <= 1'b0;
    ap(8'h00, 8'h81, 8'h00, 8'h01, 1, 16'h9000, 20);
    rd(ADDR_STATUS, 32'h9000_0004, AXI_OKAY);
    rd(8'h40, REG_RST, AXI_SLVERR);
    wr(ADDR_STATUS, 32'h0000_0001, AXI_SLVERR);
    rd(ADDR_CTRL, REG_RST, AXI_OKAY);
    wr(ADDR_SELECT, 32'h0000_0101, AXI_OKAY);
    rd(ADDR_SELECT, 32'h0000_0101, AXI_OKAY);
    ap(8'h00, 8'h80, 8'h00, 8'h01, 1, 16'h6982, 0);
    give_verdict();
  end
endmodule : testbench
